// *** pkg/quad_pkg.sv ***
// Purpose: Shared constants, register map and carrier types of the quadrature counter block
// Assumes: 10 MHz aclk, AXI4-Lite with 32-bit data
// Notes:   Register indexes are word indexes; byte address is four times the index
`default_nettype none
package quad_pkg;
  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 16;
  localparam int IDX_W  = 14;

  // ---------------------------------------------------------------------------
  // Register indexes (byte address = index * 4)
  // ---------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_FMT_S1    = 14'h19ca;
  localparam logic [IDX_W-1:0] IDX_FMT_S2    = 14'h19d3;
  localparam logic [IDX_W-1:0] IDX_MODE12_S1 = 14'h19f0;
  localparam logic [IDX_W-1:0] IDX_MODE34_S1 = 14'h19f1;
  localparam logic [IDX_W-1:0] IDX_MODE12_S2 = 14'h19f3;
  localparam logic [IDX_W-1:0] IDX_MODE34_S2 = 14'h19f4;
  localparam logic [IDX_W-1:0] IDX_CTRL      = 14'h0000;
  localparam logic [IDX_W-1:0] IDX_RING_BASE = 14'h0010;
  localparam logic [IDX_W-1:0] IDX_STAT_BASE = 14'h0020;
  localparam logic [IDX_W-1:0] IDX_PV_BASE   = 14'h0030;
  localparam logic [IDX_W-1:0] IDX_CH_MASK   = 14'h3ffc;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int FMT_LSB       = 0;
  localparam int OTYPE_LSB     = 8;
  localparam int FIELD_W       = 4;
  localparam int CH_FIELD_W    = 8;
  localparam int CTRL_RST_LSB  = 0;
  localparam int CTRL_STOP_LSB = 12;
  localparam int CTRL_RUN_BIT  = 16;
  localparam int ST_RUN_BIT    = 12;
  localparam int ST_CMP_BIT    = 13;
  localparam int ST_OVF_BIT    = 14;
  localparam int ST_SVERR_BIT  = 15;
  localparam int OPT_SWONLY_BIT = 0;
  localparam int OPT_RING_BIT   = 1;
  localparam int OPT_HIFREQ_BIT = 2;

  // ---------------------------------------------------------------------------
  // Codes and values
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  MODE_QUAD_X1 = 4'h0;
  localparam logic [3:0]  MODE_QUAD_X2 = 4'h1;
  localparam logic [3:0]  MODE_QUAD_X4 = 4'h2;
  localparam logic [3:0]  MODE_UPDOWN  = 4'h3;
  localparam logic [3:0]  MODE_PULSDIR = 4'h4;
  localparam logic [3:0]  FMT_BCD      = 4'h1;
  localparam logic [3:0]  BCD_SIGN     = 4'hf;
  localparam logic [31:0] LIN_MAX      = 32'h07ffffff;
  localparam logic [31:0] LIN_MIN      = 32'hf8000000;
  localparam logic [31:0] RING_LIM     = 32'h07ffffff;
  localparam logic [31:0] RING_RESET   = 32'h07ffffff;
  localparam logic [31:0] SETUP_RESET  = 32'h00000000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ---------------------------------------------------------------------------
  // Timing: input filter sample ticks
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ       = 10000000;
  localparam int LO_FREQ_HZ   = 50000;
  localparam int HI_FREQ_HZ   = 500000;
  localparam int FILT_SAMPLES = 4;
  localparam int TICK_LO_CYC  = CLK_HZ / (LO_FREQ_HZ * 2 * FILT_SAMPLES);
  localparam int TICK_HI_CYC  = CLK_HZ / (HI_FREQ_HZ * 2 * FILT_SAMPLES);
  localparam int TICK_W       = 8;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  // Option nibble sits above the mode nibble in each counter byte
  typedef struct packed {
    logic [3:0] opt;
    logic [3:0] mode;
  } ch_cfg_t;
endpackage
`default_nettype wire

// *** core/quad_encoder_counter.sv ***
// Purpose: Four independent 32-bit encoder counters with AXI4-Lite register access
// Assumes: 10 MHz aclk, synchronous active-low reset, encoder pins asynchronous
// Notes:   Mode words latched at run start; value format only at first run start; output type applied at once
//
// Operation
// - Format field picks binary or BCD values
// - Output-type field picks sourcing or sinking outputs
// - Mode field picks quadrature, up/down, pulse/direction
// - Option field picks frequency, range, reset method
// - Four counter channels; run bit, value format and output type are shared
// - Quadrature counts by A/B phase relationship
// - 1x, 2x, 4x quadrature edge counting
// - Up/down: A increments, B decrements
// - Pulse/direction: A pulses, B sets direction
// - Ring range wraps between zero and maximum
// - Ring maximum programmed by host, range checked
// - Linear range with overflow and underflow detection
// - Hold value at limit and halt
// - Status bit 14 flags overflow/underflow
// - Values cleared at run start and finish
// - Phase-Z armed reset or software reset
// - Stop bit halts counter until cleared
`default_nettype none
module quad_encoder_counter #(
  parameter int SLOT = 1
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire quad_pkg::axil_req_t          axi_req,
  output var  quad_pkg::axil_rsp_t          axi_rsp,
  input  wire logic [quad_pkg::NUM_CH-1:0]  phase_a,
  input  wire logic [quad_pkg::NUM_CH-1:0]  phase_b,
  input  wire logic [quad_pkg::NUM_CH-1:0]  phase_z,
  output logic      [quad_pkg::NUM_CH-1:0]  out_sink
);
  import quad_pkg::*;

  localparam logic [31:0] SETUP_KEEP = 32'h0000ffff;

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = (idx == IDX_FMT_S1) || (idx == IDX_FMT_S2) || (idx == IDX_MODE12_S1) ||
                (idx == IDX_MODE34_S1) || (idx == IDX_MODE12_S2) || (idx == IDX_MODE34_S2) ||
                (idx == IDX_CTRL) || ((idx & IDX_CH_MASK) == IDX_RING_BASE) ||
                ((idx & IDX_CH_MASK) == IDX_STAT_BASE) || ((idx & IDX_CH_MASK) == IDX_PV_BASE);
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    apply_strb = old_v;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        apply_strb[k*8 +: 8] = new_v[k*8 +: 8];
      end
    end
  endfunction

  function automatic logic [31:0] bin_to_bcd(input logic [31:0] v);
    logic [23:0] mag;
    logic [31:0] bcd;
    mag = v[31] ? 24'((~v) + 32'h00000001) : v[23:0];
    bcd = 32'h00000000;
    for (int k = 23; k >= 0; k--) begin
      for (int d = 0; d < 8; d++) begin
        if (bcd[d*4 +: 4] > 4'h4) begin
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[30:0], mag[k]};
    end
    if (v[31]) begin
      bcd[31:28] = BCD_SIGN;
    end
    bin_to_bcd = bcd;
  endfunction

  function automatic logic [31:0] bcd_to_bin(input logic [31:0] v);
    logic [31:0] acc;
    acc = 32'h00000000;
    for (int d = 7; d >= 0; d--) begin
      acc = 32'((acc << 3) + (acc << 1)) + {28'h0000000, v[d*4 +: 4]};
    end
    bcd_to_bin = acc;
  endfunction

  // Returns {step, up}
  function automatic logic [1:0] count_step(input logic [3:0] mode, input logic a0, input logic b0,
                                            input logic a1, input logic b1);
    logic a_r, a_f, b_r, b_f;
    a_r = !a0 && a1;
    a_f = a0 && !a1;
    b_r = !b0 && b1;
    b_f = b0 && !b1;
    count_step = 2'b00;
    case (mode)
      MODE_QUAD_X1: begin
        if (a_r && !b1 && !b0) count_step = 2'b11;
        else if (a_f && !b1 && !b0) count_step = 2'b10;
      end
      MODE_QUAD_X2, MODE_QUAD_X4: begin
        if ((a_r || a_f) && (b0 == b1)) count_step = {1'b1, a_r ^ b1};
        else if (mode == MODE_QUAD_X4 && (b_r || b_f) && (a0 == a1)) begin
          count_step = {1'b1, b_r ^ !a1};
        end
      end
      MODE_UPDOWN: begin
        if (a_r && !b_r) count_step = 2'b11;
        else if (b_r && !a_r) count_step = 2'b10;
      end
      MODE_PULSDIR: begin
        if (a_r) count_step = {1'b1, b1};
      end
      default: count_step = 2'b00;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [31:0] fmt_s1_r, fmt_s2_r, mode12_s1_r, mode34_s1_r, mode12_s2_r, mode34_s2_r;
  logic [31:0] ctrl_r;
  logic [31:0] ring_r [NUM_CH];
  logic [31:0] pv_all    [NUM_CH];
  logic [31:0] stat_all  [NUM_CH];
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic        aw_got_r, w_got_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r, wdata_r;
  logic [3:0]  wstrb_r;
  logic [IDX_W-1:0] aw_idx_r;
  logic        wr_fire;
  logic [31:0] fmt_sel, mode12_sel, mode34_sel;

  assign wr_fire    = aw_got_r && w_got_r && !bvalid_r;
  assign fmt_sel    = (SLOT == 2) ? fmt_s2_r    : fmt_s1_r;
  assign mode12_sel = (SLOT == 2) ? mode12_s2_r : mode12_s1_r;
  assign mode34_sel = (SLOT == 2) ? mode34_s2_r : mode34_s1_r;

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channels
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_got_r  <= 1'b0;
      aw_idx_r  <= '0;
    end else if (axi_req.awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_got_r  <= 1'b1;
      aw_idx_r  <= axi_req.awaddr[ADDR_W-1:2];
    end else if (bvalid_r && axi_req.bready) begin
      awready_r <= 1'b1;
      aw_got_r  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      w_got_r  <= 1'b0;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
    end else if (axi_req.wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_got_r  <= 1'b1;
      wdata_r  <= axi_req.wdata;
      wstrb_r  <= axi_req.wstrb;
    end else if (bvalid_r && axi_req.bready) begin
      wready_r <= 1'b1;
      w_got_r  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && axi_req.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Register writes; status and present values are read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_s1_r    <= SETUP_RESET;
      fmt_s2_r    <= SETUP_RESET;
      mode12_s1_r <= SETUP_RESET;
      mode34_s1_r <= SETUP_RESET;
      mode12_s2_r <= SETUP_RESET;
      mode34_s2_r <= SETUP_RESET;
      ctrl_r      <= 32'h00000000;
      for (int i = 0; i < NUM_CH; i++) begin
        ring_r[i] <= RING_RESET;
      end
    end else if (wr_fire) begin
      case (aw_idx_r)
        IDX_FMT_S1:    fmt_s1_r    <= apply_strb(fmt_s1_r, wdata_r, wstrb_r) & SETUP_KEEP;
        IDX_FMT_S2:    fmt_s2_r    <= apply_strb(fmt_s2_r, wdata_r, wstrb_r) & SETUP_KEEP;
        IDX_MODE12_S1: mode12_s1_r <= apply_strb(mode12_s1_r, wdata_r, wstrb_r) & SETUP_KEEP;
        IDX_MODE34_S1: mode34_s1_r <= apply_strb(mode34_s1_r, wdata_r, wstrb_r) & SETUP_KEEP;
        IDX_MODE12_S2: mode12_s2_r <= apply_strb(mode12_s2_r, wdata_r, wstrb_r) & SETUP_KEEP;
        IDX_MODE34_S2: mode34_s2_r <= apply_strb(mode34_s2_r, wdata_r, wstrb_r) & SETUP_KEEP;
        IDX_CTRL:      ctrl_r      <= apply_strb(ctrl_r, wdata_r, wstrb_r);
        default: begin
          if ((aw_idx_r & IDX_CH_MASK) == IDX_RING_BASE) begin
            ring_r[aw_idx_r[1:0]] <= apply_strb(ring_r[aw_idx_r[1:0]], wdata_r, wstrb_r);
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channels
  // ---------------------------------------------------------------------------
  logic [IDX_W-1:0] ar_idx;
  logic [31:0]      rd_word;
  assign ar_idx = axi_req.araddr[ADDR_W-1:2];

  always_comb begin
    rd_word = 32'h00000000;
    case (ar_idx)
      IDX_FMT_S1:    rd_word = fmt_s1_r;
      IDX_FMT_S2:    rd_word = fmt_s2_r;
      IDX_MODE12_S1: rd_word = mode12_s1_r;
      IDX_MODE34_S1: rd_word = mode34_s1_r;
      IDX_MODE12_S2: rd_word = mode12_s2_r;
      IDX_MODE34_S2: rd_word = mode34_s2_r;
      IDX_CTRL:      rd_word = ctrl_r;
      default: begin
        if ((ar_idx & IDX_CH_MASK) == IDX_RING_BASE) rd_word = ring_r[ar_idx[1:0]];
        else if ((ar_idx & IDX_CH_MASK) == IDX_STAT_BASE) rd_word = stat_all[ar_idx[1:0]];
        else if ((ar_idx & IDX_CH_MASK) == IDX_PV_BASE) rd_word = pv_all[ar_idx[1:0]];
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
    end else if (axi_req.arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_word;
      rresp_r   <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && axi_req.rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  assign axi_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r, bresp: bresp_r,
                     arready: arready_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

  // ---------------------------------------------------------------------------
  // Run sequencing, format and output type
  // ---------------------------------------------------------------------------
  logic run_q_r, fmt_done_r, bcd_r, run_edge;
  assign run_edge = ctrl_r[CTRL_RUN_BIT] ^ run_q_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q_r    <= 1'b0;
      fmt_done_r <= 1'b0;
      bcd_r      <= 1'b0;
    end else begin
      run_q_r <= ctrl_r[CTRL_RUN_BIT];
      if (ctrl_r[CTRL_RUN_BIT] && !run_q_r && !fmt_done_r) begin
        fmt_done_r <= 1'b1;
        bcd_r      <= (fmt_sel[FMT_LSB +: FIELD_W] == FMT_BCD);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_sink <= '0;
    end else begin
      out_sink <= {NUM_CH{fmt_sel[OTYPE_LSB +: FIELD_W] != 4'h0}};
    end
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers and filter tick dividers
  // ---------------------------------------------------------------------------
  logic [NUM_CH-1:0] a_s1_r, a_s2_r, b_s1_r, b_s2_r, z_s1_r, z_s2_r;
  logic [TICK_W-1:0] lo_cnt_r, hi_cnt_r;
  logic              tick_lo_r, tick_hi_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_s1_r <= '0;
      a_s2_r <= '0;
      b_s1_r <= '0;
      b_s2_r <= '0;
      z_s1_r <= '0;
      z_s2_r <= '0;
    end else begin
      a_s1_r <= phase_a;
      a_s2_r <= a_s1_r;
      b_s1_r <= phase_b;
      b_s2_r <= b_s1_r;
      z_s1_r <= phase_z;
      z_s2_r <= z_s1_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_cnt_r  <= '0;
      hi_cnt_r  <= '0;
      tick_lo_r <= 1'b0;
      tick_hi_r <= 1'b0;
    end else begin
      tick_lo_r <= (lo_cnt_r == TICK_W'(TICK_LO_CYC - 1));
      tick_hi_r <= (hi_cnt_r == TICK_W'(TICK_HI_CYC - 1));
      lo_cnt_r  <= (lo_cnt_r == TICK_W'(TICK_LO_CYC - 1)) ? '0 : lo_cnt_r + 1'b1;
      hi_cnt_r  <= (hi_cnt_r == TICK_W'(TICK_HI_CYC - 1)) ? '0 : hi_cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Counter channels
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    ch_cfg_t     cfg_r;
    logic [2:0]  filt_r, filt_q_r;
    logic [1:0]  ha_r, hb_r, hz_r;
    logic [31:0] pv_r;
    logic        ovf_r, zarm_r, rst_q_r, tick, rst_bit, stop_bit, ring_mode, sv_err, enable;
    logic [1:0]  step;
    logic [31:0] ring_max;
    ch_cfg_t     cfg_src;

    assign cfg_src   = (i < 2) ? ch_cfg_t'(mode12_sel[(i % 2) * CH_FIELD_W +: CH_FIELD_W])
                               : ch_cfg_t'(mode34_sel[(i % 2) * CH_FIELD_W +: CH_FIELD_W]);
    assign tick      = cfg_r.opt[OPT_HIFREQ_BIT] ? tick_hi_r : tick_lo_r;
    assign rst_bit   = ctrl_r[CTRL_RST_LSB + i];
    assign stop_bit  = ctrl_r[CTRL_STOP_LSB + i];
    assign ring_mode = cfg_r.opt[OPT_RING_BIT];
    assign ring_max  = bcd_r ? bcd_to_bin(ring_r[i]) : ring_r[i];
    assign sv_err    = ring_mode && ((ring_max == 32'h00000000) || (ring_max > RING_LIM));
    assign enable    = ctrl_r[CTRL_RUN_BIT] && !stop_bit && !ovf_r && !sv_err;
    assign step      = count_step(cfg_r.mode, filt_q_r[0], filt_q_r[1], filt_r[0], filt_r[1]);

    // Setup sampled when operation starts
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_r <= '0;
      end else if (ctrl_r[CTRL_RUN_BIT] && !run_q_r) begin
        cfg_r <= cfg_src;
      end
    end

    // Glitch filter: level accepted after three equal samples
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ha_r     <= '0;
        hb_r     <= '0;
        hz_r     <= '0;
        filt_r   <= '0;
        filt_q_r <= '0;
      end else begin
        filt_q_r <= filt_r;
        if (tick) begin
          ha_r <= {ha_r[0], a_s2_r[i]};
          hb_r <= {hb_r[0], b_s2_r[i]};
          hz_r <= {hz_r[0], z_s2_r[i]};
          if (ha_r == {2{a_s2_r[i]}}) filt_r[0] <= a_s2_r[i];
          if (hb_r == {2{b_s2_r[i]}}) filt_r[1] <= b_s2_r[i];
          if (hz_r == {2{z_s2_r[i]}}) filt_r[2] <= z_s2_r[i];
        end
      end
    end

    // Present value, resets and range handling
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pv_r    <= 32'h00000000;
        ovf_r   <= 1'b0;
        zarm_r  <= 1'b0;
        rst_q_r <= 1'b0;
      end else begin
        rst_q_r <= rst_bit;
        if (rst_bit && !rst_q_r && !cfg_r.opt[OPT_SWONLY_BIT]) begin
          zarm_r <= 1'b1;
        end
        if (run_edge) begin
          pv_r   <= 32'h00000000;
          ovf_r  <= 1'b0;
          zarm_r <= 1'b0;
        end else if (rst_bit && !rst_q_r && cfg_r.opt[OPT_SWONLY_BIT]) begin
          pv_r  <= 32'h00000000;
          ovf_r <= 1'b0;
        end else if (zarm_r && filt_r[2] && !filt_q_r[2]) begin
          pv_r   <= 32'h00000000;
          ovf_r  <= 1'b0;
          zarm_r <= 1'b0;
        end else if (enable && step[1]) begin
          if (ring_mode) begin
            if (step[0]) pv_r <= (pv_r >= ring_max) ? 32'h00000000 : pv_r + 32'h00000001;
            else pv_r <= (pv_r == 32'h00000000) ? ring_max : pv_r - 32'h00000001;
          end else if (step[0]) begin
            if (pv_r == LIN_MAX) ovf_r <= 1'b1;
            else pv_r <= pv_r + 32'h00000001;
          end else begin
            if (pv_r == LIN_MIN) ovf_r <= 1'b1;
            else pv_r <= pv_r - 32'h00000001;
          end
        end
      end
    end

    assign pv_all[i] = bcd_r ? bin_to_bcd(pv_r) : pv_r;
    always_comb begin
      stat_all[i]               = 32'h00000000;
      stat_all[i][ST_RUN_BIT]   = enable;
      stat_all[i][ST_OVF_BIT]   = ovf_r;
      stat_all[i][ST_SVERR_BIT] = sv_err;
    end
  end

endmodule
`default_nettype wire

// *** bench/quad_encoder_counter_sva.sv ***
// Purpose: Bus handshake checks
// Assumes: One clock domain
// Notes:   Bound to the counter block
`default_nettype none
module quad_encoder_counter_sva (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire quad_pkg::axil_req_t axi_req,
  input wire quad_pkg::axil_rsp_t axi_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  import quad_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_t; axi_req.awvalid && axi_rsp.awready; endsequence
  sequence w_t; axi_req.wvalid && axi_rsp.wready; endsequence
  sequence ar_t; axi_req.arvalid && axi_rsp.arready; endsequence
  bresp_time_a: assert property (aw_t and w_t |=> ##1 axi_rsp.bvalid)
    else $error("write answer late");
  bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write answer dropped");
  aw_block_a: assert property (aw_t |=> !axi_rsp.awready)
    else $error("second write taken");
  b_done_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid && axi_rsp.wready)
    else $error("write not closed");
  rdata_time_a: assert property (ar_t |=> axi_rsp.rvalid)
    else $error("read answer late");
  rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=> $stable(axi_rsp.rdata))
    else $error("read data moved");
  r_done_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid && axi_rsp.arready)
    else $error("read not closed");
  bad_read_a: assert property (ar_t ##0 axi_req.araddr == 16'hfff0 |=> axi_rsp.rresp == RESP_SLVERR)
    else $error("unmapped read accepted");
endmodule
bind quad_encoder_counter quad_encoder_counter_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp));
`default_nettype wire

// *** bench/encoder_model.sv ***
// Purpose: Encoder pins of four channels
// Assumes: High count frequency option
// Notes:   Each level held HOLD cycles
`default_nettype none
module encoder_model #(
  parameter int HOLD = 12
) (
  input  wire logic       aclk,
  output var  logic [3:0] phase_a,
  output var  logic [3:0] phase_b,
  output var  logic [3:0] phase_z
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pos [4] = '{default: 2'h0};
  initial begin
    phase_a = 4'h0;
    phase_b = 4'h0;
    phase_z = 4'h0;
  end
  task automatic lvl(input int ch, input int sel, input logic v);
    @(posedge aclk);
    case (sel)
      0: phase_a[ch] <= v;
      1: phase_b[ch] <= v;
      default: phase_z[ch] <= v;
    endcase
    repeat (HOLD) @(posedge aclk);
  endtask
  task automatic pulse(input int ch, input int sel);
    lvl(ch, sel, 1'b1);
    lvl(ch, sel, 1'b0);
  endtask
  // One gray step, one phase changes
  task automatic quad(input int ch, input bit up);
    logic [1:0] p;
    p = up ? pos[ch] + 2'h1 : pos[ch] - 2'h1;
    if ((^p) != (^pos[ch])) lvl(ch, 0, ^p);
    else lvl(ch, 1, p[1]);
    pos[ch] = p;
  endtask
endmodule
`default_nettype wire

// *** bench/quad_encoder_counter_tb_top.sv ***
// Purpose: Self-checking bench of the counter block
// Assumes: Slot 1 setup words, binary values
// Notes:   Drivers queue expected bus answers
`default_nettype none
module quad_encoder_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import quad_pkg::*;
  logic        aclk;
  logic        aresetn;
  axil_req_t   req;
  axil_rsp_t   rsp;
  logic [3:0]  pa, pb, pz, sink;
  int          fail_count, n_tests, n;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  quad_encoder_counter u_quad_encoder_counter (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .phase_a(pa), .phase_b(pb), .phase_z(pz), .out_sink(sink));
  encoder_model u_encoder_model (.aclk(aclk), .phase_a(pa), .phase_b(pb), .phase_z(pz));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input bit w, input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
    if (w) bq.push_back(er);
    else rq.push_back({er, d});
    @(posedge aclk);
    req.awaddr <= {idx, 2'b00};
    req.araddr <= {idx, 2'b00};
    req.wdata <= d;
    req.awvalid <= w;
    req.wvalid <= w;
    req.bready <= w;
    req.arvalid <= !w;
    req.rready <= !w;
    for (int i = 0; i <= 60; i++) begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.arready) req.arvalid <= 1'b0;
      if (w ? rsp.bvalid : rsp.rvalid) break;
      if (i == 60) begin
        fail_count++;
        wrap_up();
      end
    end
    req.bready <= 1'b0;
    req.rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    if (rsp.bvalid && req.bready) chk({32'h0, rsp.bresp}, {32'h0, bq.pop_front()});
    if (rsp.rvalid && req.rready) chk({rsp.rresp, rsp.rdata}, rq.pop_front());
  end
  initial begin
    req = '0;
    req.wstrb = 4'hf;
    aresetn = 1'b0;
    void'($urandom(89985));
    n = $urandom % 4 + 1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, IDX_FMT_S1, SETUP_RESET, RESP_OKAY);
    bus(0, IDX_RING_BASE, RING_RESET, RESP_OKAY);
    bus(0, 14'h3ffc, 32'h0, RESP_SLVERR);
    bus(1, 14'h3ffc, 32'h1, RESP_SLVERR);
    $display("test reset and map done");
    bus(1, IDX_FMT_S1, 32'h0100, RESP_OKAY);
    bus(1, IDX_MODE12_S1, 32'h5342, RESP_OKAY);
    bus(1, IDX_MODE34_S1, 32'h7064, RESP_OKAY);
    bus(1, IDX_RING_BASE + 14'h2, 32'h5, RESP_OKAY);
    bus(1, IDX_RING_BASE + 14'h3, 32'h3, RESP_OKAY);
    bus(0, IDX_MODE12_S1, 32'h5342, RESP_OKAY);
    bus(1, IDX_CTRL, 32'h10000, RESP_OKAY);
    chk({30'h0, sink}, 34'hf);
    repeat (6) u_encoder_model.quad(0, 1'b1);
    repeat (2) u_encoder_model.quad(0, 1'b0);
    repeat (n) u_encoder_model.pulse(1, 0);
    u_encoder_model.pulse(1, 1);
    u_encoder_model.lvl(2, 1, 1'b1);
    repeat (7) u_encoder_model.pulse(2, 0);
    repeat (4) u_encoder_model.quad(3, 1'b0);
    bus(0, IDX_PV_BASE, 32'h4, RESP_OKAY);
    bus(0, IDX_PV_BASE + 14'h1, 32'(n - 1), RESP_OKAY);
    bus(0, IDX_PV_BASE + 14'h2, 32'h1, RESP_OKAY);
    bus(0, IDX_PV_BASE + 14'h3, 32'h3, RESP_OKAY);
    bus(0, IDX_STAT_BASE, 32'h1000, RESP_OKAY);
    $display("test counting modes done");
    bus(1, IDX_CTRL, 32'h12000, RESP_OKAY);
    u_encoder_model.pulse(1, 0);
    bus(0, IDX_STAT_BASE + 14'h1, 32'h0, RESP_OKAY);
    bus(0, IDX_PV_BASE + 14'h1, 32'(n - 1), RESP_OKAY);
    bus(1, IDX_CTRL, 32'h10000, RESP_OKAY);
    u_encoder_model.pulse(1, 0);
    bus(0, IDX_PV_BASE + 14'h1, 32'(n), RESP_OKAY);
    bus(1, IDX_CTRL, 32'h10003, RESP_OKAY);
    bus(0, IDX_PV_BASE + 14'h1, 32'h0, RESP_OKAY);
    bus(0, IDX_PV_BASE, 32'h4, RESP_OKAY);
    u_encoder_model.pulse(0, 2);
    bus(0, IDX_PV_BASE, 32'h0, RESP_OKAY);
    bus(1, IDX_CTRL, 32'h0, RESP_OKAY);
    bus(0, IDX_PV_BASE + 14'h2, 32'h0, RESP_OKAY);
    $display("test stop and resets done");
    wrap_up();
  end
endmodule
`default_nettype wire
